/* logic/irq_arb_pkg.sv */
// constants shared by the interrupt priority arbiter
package irq_arb_pkg;
	localparam int          CHANNELS       = 8;
	localparam logic [7:0]  IDX_CENTRAL    = 8'hE6;
	localparam logic [7:0]  IDX_EMR_TWO    = 8'hF6;
	localparam logic [7:0]  IDX_INT_SEG    = 8'hF0;
	localparam logic [7:0]  IDX_CODE_SEG   = 8'hF1;
	localparam logic [7:0]  IDX_VECTOR     = 8'hF2;
	localparam logic [7:0]  IDX_PRIO_LO    = 8'hF3;
	localparam logic [7:0]  IDX_PRIO_HI    = 8'hF4;
	localparam logic [7:0]  IDX_TOP_CFG    = 8'hF5;
	localparam logic [7:0]  IDX_STATUS     = 8'hF7;
	localparam int          CTRL_MODE      = 3;
	localparam int          CTRL_ENABLE    = 4;
	localparam int          CTRL_TOP_MASK  = 5;
	localparam int          CTRL_TOP_ACT   = 6;
	localparam int          EMR_SEG_SAVE   = 6;
	localparam int          TOP_NMI_BIT    = 0;
	localparam logic [2:0]  LEVEL_RESET    = 3'h7;
	localparam logic [2:0]  LEVEL_LOWEST   = 3'h7;
	localparam logic [7:0]  TOP_VECTOR     = 8'h04;
	localparam logic [7:0]  SEG_RESET      = 8'h00;
	localparam logic [7:0]  VECTOR_RESET   = 8'h00;
	localparam logic [15:0] PRIO_RESET     = 16'h7777;
	localparam int          PRIO_SLOT      = 4;
	localparam logic [3:0]  DEPTH_ONE      = 4'h1;
	typedef enum logic [3:0] {
		S_IDLE, S_PUSH_PCL, S_PUSH_PCH, S_PUSH_CS, S_PUSH_FLG, S_VECTOR,
		S_POP_FLG, S_POP_CS, S_POP_PCH, S_POP_PCL
	} seq_state_t;
endpackage : irq_arb_pkg

/* logic/interrupt_priority_arbiter.sv */
// interrupt priority arbiter with entry/return sequencer and wishbone registers
// What this block does
// - without segment save, routines run from the interrupt segment; stack pc and flags only.
// - with segment save, entry pushes code segment then loads it from interrupt segment.
// - with segment save, return pops the code segment back from the stack.
// - each channel has a 3-bit priority, 0 highest and 7 lowest.
// - top-level channel, maskable or non-maskable, is never preempted once in service.
// - current priority level resets to 7, changed by software or hardware.
// - every instruction boundary compares all pending requests against each other.
// - winner acknowledged only if strictly below current level; top level overrides all.
// - level-7 requests are never acknowledged, only polled.
// - in nested mode, an equal level never preempts a running routine.
// - ties go to A even, A odd, B even, B odd, C, then D.
// - current priority level is a readable and writable 3-bit field.
// - arbitration mode bit: clear means concurrent (reset), set means nested.
// - concurrent mode leaves the current level untouched on entry and return.
// - entry clears enable, pushes pcl, pch, segment, flags, loads pc from vector.
// - return pops flags, segment, pch, pcl, sets enable, reverts to code segment.
// - requests blocked by a cleared enable wait for the next enable instruction.
// - concurrent mode acknowledges passing requests regardless of the running routine.
// - without segment save a routine is confined to one 64K segment.
// - vector table is the first 256 bytes of the interrupt segment.
// - top-level vector sits at 0004h and 0005h of the interrupt segment.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module interrupt_priority_arbiter
	import irq_arb_pkg::*;
(
	input  wire logic        clock,           // core clock, 125 MHz
	input  wire logic        reset,           // synchronous, active high
	input  wire logic        wb_cyc_i,        // wishbone cycle
	input  wire logic        wb_stb_i,        // wishbone strobe
	input  wire logic        wb_we_i,         // wishbone write
	input  wire logic [11:0] wb_adr_i,        // byte address
	input  wire logic [3:0]  wb_sel_i,        // byte enables
	input  wire logic [31:0] wb_dat_i,        // write data
	output logic      [31:0] wb_dat_o,        // read data
	output logic             wb_ack_o,        // transfer acknowledge
	input  wire logic [7:0]  irq_request,     // pending flags, pair a even first
	output logic      [7:0]  irq_ack,         // one-cycle acknowledge to winner
	input  wire logic        top_request,     // top-level channel pending
	output logic             top_ack,         // one-cycle acknowledge to top level
	input  wire logic        instr_boundary,  // one cycle per instruction
	input  wire logic        enable_interrupts_instr, // enable instruction executed
	input  wire logic        iret_instr,      // interrupt return executed
	input  wire logic [15:0] pc_current,      // pc of interrupted instruction
	input  wire logic [7:0]  flag_register,   // flags of the core
	output logic             stack_push,      // push stack_wdata
	output logic      [7:0]  stack_wdata,     // byte to push
	output logic             stack_pop,       // pop, stack_rdata valid this cycle
	input  wire logic [7:0]  stack_rdata,     // popped byte
	output logic             vector_fetch,    // read vector_word at vector_addr
	output logic      [21:0] vector_addr,     // byte address of vector
	input  wire logic [15:0] vector_word,     // vector fetched, valid with vector_fetch
	output logic             pc_load,         // load pc_value into pc
	output logic      [15:0] pc_value,        // new pc
	output logic             flags_load,      // restore flags_value
	output logic      [7:0]  flags_value,     // popped flags
	output logic      [7:0]  active_segment,  // segment fetching code now
	output logic             global_irq_enable // enable bit, for the core
);
	seq_state_t  state;
	logic [2:0]  current_priority_level;
	logic        arbitration_mode_select;
	logic        top_level_maskable;
	logic        top_level_nonmaskable;
	logic        segment_save_enable;
	logic [7:0]  extended_mode_reg_two;
	logic [7:0]  interrupt_segment_reg;
	logic [7:0]  code_segment_reg;
	logic [7:0]  vector_register;
	logic [31:0] channel_priority_level;
	logic [7:0]  nest_saved;
	logic [3:0]  depth;
	logic        top_active;
	logic [15:0] saved_pc;
	logic [7:0]  saved_flags;
	logic [7:0]  saved_segment;
	logic [7:0]  entry_vector;
	logic [15:0] popped_pc;
	logic [7:0]  reg_index;
	logic        wb_write;
	logic [7:0]  wb_byte;
	logic [3:0]  win;
	logic [2:0]  win_level;
	logic        take;
	logic        top_take;
	logic        chan_take;
	logic        return_done;
	logic [3:0]  next_restore;

	function automatic logic [2:0] chan_level(input logic [31:0] prio, input logic [2:0] ch);
		chan_level = prio[ch*PRIO_SLOT +: 3];
	endfunction : chan_level

	// lowest index wins ties, so scan from the highest index downward
	function automatic logic [3:0] arbitrate(input logic [7:0] req, input logic [31:0] prio);
		logic [3:0] best;
		best = '0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (req[i] && (!best[3] || chan_level(prio, 3'(i)) <= chan_level(prio, best[2:0]))) begin
				best = {1'b1, 3'(i)};
			end
		end
		arbitrate = best;
	endfunction : arbitrate

	function automatic logic [3:0] lowest_set(input logic [7:0] bits);
		logic [3:0] r;
		r = '0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (bits[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		lowest_set = r;
	endfunction : lowest_set

	assign reg_index = wb_adr_i[9:2];
	// a write lands on the edge where the master samples ack, never earlier
	assign wb_write  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	assign wb_byte   = wb_dat_i[7:0];
	assign segment_save_enable = extended_mode_reg_two[EMR_SEG_SAVE];

	always_comb begin
		win          = arbitrate(irq_request, channel_priority_level);
		win_level    = chan_level(channel_priority_level, win[2:0]);
		take         = instr_boundary && state == S_IDLE && !iret_instr;
		// the top-level channel ignores the enable only when non-maskable
		top_take     = take && top_request && !top_active
			&& (top_level_nonmaskable || (top_level_maskable && global_irq_enable));
		// strict compare: level 7 can never pass and, in nested mode, equal levels never nest
		chan_take    = take && !top_take && !top_active && global_irq_enable && win[3]
			&& win_level < current_priority_level;
		irq_ack      = chan_take ? 8'(1) << win[2:0] : '0;
		top_ack      = top_take;
		return_done  = state == S_POP_PCL;
		next_restore = lowest_set(nest_saved);
	end

	// central control: level, mode, enable
	always_ff @(posedge clock) begin
		if (reset) begin
			current_priority_level  <= LEVEL_RESET;
			arbitration_mode_select <= 1'b0;
			global_irq_enable       <= 1'b0;
			top_level_maskable      <= 1'b0;
			nest_saved              <= '0;
		end else begin
			if (wb_write && reg_index == IDX_CENTRAL) begin
				current_priority_level  <= wb_byte[2:0];
				arbitration_mode_select <= wb_byte[CTRL_MODE];
				global_irq_enable       <= wb_byte[CTRL_ENABLE];
				top_level_maskable      <= wb_byte[CTRL_TOP_MASK];
			end
			if (enable_interrupts_instr || return_done) begin
				global_irq_enable <= 1'b1;
			end
			// entry must win over a simultaneous enable instruction, or the routine starts enabled
			if (chan_take || top_take) begin
				global_irq_enable <= 1'b0;
			end
			if (chan_take && arbitration_mode_select) begin
				nest_saved[current_priority_level] <= 1'b1;
				current_priority_level             <= win_level;
			end
			if (return_done && arbitration_mode_select && !top_active && next_restore[3]) begin
				nest_saved[next_restore[2:0]] <= 1'b0;
				current_priority_level        <= next_restore[2:0];
			end
			// concurrent mode: no hardware change of the level at all
		end
	end

	// configuration registers written only by software
	always_ff @(posedge clock) begin
		if (reset) begin
			extended_mode_reg_two  <= SEG_RESET;
			interrupt_segment_reg  <= SEG_RESET;
			vector_register        <= VECTOR_RESET;
			channel_priority_level <= {PRIO_RESET, PRIO_RESET};
			top_level_nonmaskable  <= 1'b0;
		end else if (wb_write) begin
			unique case (reg_index)
				IDX_EMR_TWO:  extended_mode_reg_two <= wb_byte;
				IDX_INT_SEG:  interrupt_segment_reg <= wb_byte;
				IDX_VECTOR:   vector_register <= wb_byte;
				IDX_PRIO_LO:  channel_priority_level[15:0] <= wb_dat_i[15:0];
				IDX_PRIO_HI:  channel_priority_level[31:16] <= wb_dat_i[15:0];
				IDX_TOP_CFG:  top_level_nonmaskable <= wb_byte[TOP_NMI_BIT];
				default: ;
			endcase
		end
	end

	// code segment: hardware load and pop take precedence over software
	always_ff @(posedge clock) begin
		if (reset) begin
			code_segment_reg <= SEG_RESET;
		end else if (state == S_VECTOR && segment_save_enable) begin
			code_segment_reg <= interrupt_segment_reg;
		end else if (state == S_POP_CS) begin
			code_segment_reg <= stack_rdata;
		end else if (wb_write && reg_index == IDX_CODE_SEG) begin
			code_segment_reg <= wb_byte;
		end
	end

	// service depth and top-level tracking
	always_ff @(posedge clock) begin
		if (reset) begin
			depth      <= '0;
			top_active <= 1'b0;
		end else begin
			if ((chan_take || top_take) && !return_done) begin
				depth <= depth + DEPTH_ONE;
			end else if (return_done && !(chan_take || top_take) && depth != '0) begin
				depth <= depth - DEPTH_ONE;
			end
			// nothing nests inside the top level, so the next return is its own
			if (top_take) begin
				top_active <= 1'b1;
			end else if (return_done) begin
				top_active <= 1'b0;
			end
		end
	end

	// entry and return sequencer
	always_ff @(posedge clock) begin
		if (reset) begin
			state         <= S_IDLE;
			saved_pc      <= '0;
			saved_flags   <= '0;
			saved_segment <= '0;
			entry_vector  <= '0;
			popped_pc     <= '0;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (chan_take || top_take) begin
						saved_pc      <= pc_current;
						saved_flags   <= flag_register;
						saved_segment <= code_segment_reg;
						// upper bits from software, lower bits name the channel
						entry_vector  <= top_take ? TOP_VECTOR
							: {vector_register[7:4], win[2:0], 1'b0};
						state         <= S_PUSH_PCL;
					end else if (iret_instr) begin
						state <= S_POP_FLG;
					end
				end
				S_PUSH_PCL: state <= S_PUSH_PCH;
				S_PUSH_PCH: state <= segment_save_enable ? S_PUSH_CS : S_PUSH_FLG;
				S_PUSH_CS:  state <= S_PUSH_FLG;
				S_PUSH_FLG: state <= S_VECTOR;
				S_VECTOR:   state <= S_IDLE;
				S_POP_FLG:  state <= segment_save_enable ? S_POP_CS : S_POP_PCH;
				S_POP_CS:   state <= S_POP_PCH;
				S_POP_PCH: begin
					popped_pc[15:8] <= stack_rdata;
					state           <= S_POP_PCL;
				end
				S_POP_PCL:  state <= S_IDLE;
				default:    state <= S_IDLE;
			endcase
		end
	end

	always_comb begin
		stack_push  = state inside {S_PUSH_PCL, S_PUSH_PCH, S_PUSH_CS, S_PUSH_FLG};
		stack_pop   = state inside {S_POP_FLG, S_POP_CS, S_POP_PCH, S_POP_PCL};
		vector_fetch = state == S_VECTOR;
		unique case (state)
			S_PUSH_PCL: stack_wdata = saved_pc[7:0];
			S_PUSH_PCH: stack_wdata = saved_pc[15:8];
			S_PUSH_CS:  stack_wdata = saved_segment;
			S_PUSH_FLG: stack_wdata = saved_flags;
			default:    stack_wdata = '0;
		endcase
		vector_addr = {interrupt_segment_reg[5:0], 8'h00, entry_vector};
	end

	// pc and flags handed to the core from flops, one cycle after the step
	always_ff @(posedge clock) begin
		if (reset) begin
			pc_load     <= 1'b0;
			pc_value    <= '0;
			flags_load  <= 1'b0;
			flags_value <= '0;
		end else begin
			pc_load    <= state == S_VECTOR || state == S_POP_PCL;
			flags_load <= state == S_POP_FLG;
			if (state == S_VECTOR) begin
				pc_value <= vector_word;
			end else if (state == S_POP_PCL) begin
				pc_value <= {popped_pc[15:8], stack_rdata};
			end
			if (state == S_POP_FLG) begin
				flags_value <= stack_rdata;
			end
		end
	end

	// while any routine runs without segment save, code comes from the
	// interrupt segment; a far branch there would be lost
	always_ff @(posedge clock) begin
		if (reset) begin
			active_segment <= SEG_RESET;
		end else if (!segment_save_enable && depth != '0) begin
			active_segment <= interrupt_segment_reg;
		end else begin
			active_segment <= code_segment_reg;
		end
	end

	// wishbone slave: registered ack one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clock) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			unique case (reg_index)
				IDX_CENTRAL: wb_dat_o <= {24'h0, 1'b0, top_active, top_level_maskable, global_irq_enable,
					arbitration_mode_select, current_priority_level};
				IDX_EMR_TWO:  wb_dat_o <= {24'h0, extended_mode_reg_two};
				IDX_INT_SEG:  wb_dat_o <= {24'h0, interrupt_segment_reg};
				IDX_CODE_SEG: wb_dat_o <= {24'h0, code_segment_reg};
				IDX_VECTOR:   wb_dat_o <= {24'h0, vector_register};
				IDX_PRIO_LO:  wb_dat_o <= {16'h0, channel_priority_level[15:0]};
				IDX_PRIO_HI:  wb_dat_o <= {16'h0, channel_priority_level[31:16]};
				IDX_TOP_CFG:  wb_dat_o <= {31'h0, top_level_nonmaskable};
				IDX_STATUS:   wb_dat_o <= {16'h0, nest_saved, depth, 4'(state)};
				default:      wb_dat_o <= '0;
			endcase
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_push_short; stack_push [*3] ##1 vector_fetch; endsequence
	sequence s_push_long;  stack_push [*4] ##1 vector_fetch; endsequence
	sequence s_pops;       stack_pop [*3]; endsequence

	property p_ack_onehot;
		|irq_ack |-> $onehot(irq_ack) && !top_ack;
	endproperty
	a_ack_onehot: assert property (p_ack_onehot) else $error("several acknowledges at once");

	property p_ack_below;
		|irq_ack |-> chan_level(channel_priority_level, win[2:0]) < current_priority_level && global_irq_enable;
	endproperty
	a_ack_below: assert property (p_ack_below) else $error("acknowledge not below level");

	property p_level7;
		|irq_ack |-> chan_level(channel_priority_level, win[2:0]) != LEVEL_LOWEST;
	endproperty
	a_level7: assert property (p_level7) else $error("level 7 acknowledged");

	property p_entry_short;
		(|irq_ack || top_ack) && !segment_save_enable |=> s_push_short ##1 (pc_load && !global_irq_enable);
	endproperty
	a_entry_short: assert property (p_entry_short) else $error("short entry frame wrong");

	property p_entry_long;
		(|irq_ack || top_ack) && segment_save_enable |=> s_push_long ##1 code_segment_reg == interrupt_segment_reg;
	endproperty
	a_entry_long: assert property (p_entry_long) else $error("long entry frame wrong");

	property p_concurrent_keep;
		|irq_ack && !arbitration_mode_select && !wb_write |=> $stable(current_priority_level);
	endproperty
	a_concurrent_keep: assert property (p_concurrent_keep) else $error("level moved in concurrent mode");

	property p_top_no_preempt;
		top_active |-> irq_ack == '0 && !top_ack;
	endproperty
	a_top_no_preempt: assert property (p_top_no_preempt) else $error("top level preempted");

	property p_return;
		state == S_POP_FLG && !segment_save_enable |-> s_pops ##1 (!stack_pop && global_irq_enable && pc_load);
	endproperty
	a_return: assert property (p_return) else $error("return sequence wrong");

	property p_flags_restore;
		state == S_POP_FLG |=> flags_load && flags_value == $past(stack_rdata);
	endproperty
	a_flags_restore: assert property (p_flags_restore) else $error("flags not restored");

	property p_reset_level;
		$past(reset) |-> current_priority_level == LEVEL_RESET && !arbitration_mode_select;
	endproperty
	a_reset_level: assert property (@(posedge clock) p_reset_level) else $error("reset level wrong");
endmodule : interrupt_priority_arbiter

/* sim/core_model.sv */
// far-side model: core stack, vector memory and peripheral request flags
`timescale 1ns/1ps
module core_model (
	input  wire logic        clock,        // core clock
	input  wire logic        reset,        // synchronous, active high
	input  wire logic [7:0]  raise,        // one-cycle channel events
	input  wire logic        raise_top,    // one-cycle top-level event
	input  wire logic [7:0]  irq_ack,      // channel acknowledge
	input  wire logic        top_ack,      // top-level acknowledge
	output logic      [7:0]  irq_request,  // held pending flags
	output logic             top_request,  // held top-level flag
	input  wire logic        stack_push,   // push strobe
	input  wire logic [7:0]  stack_wdata,  // pushed byte
	input  wire logic        stack_pop,    // pop strobe
	output logic      [7:0]  stack_rdata,  // popped byte
	input  wire logic        vector_fetch, // vector read strobe
	input  wire logic [21:0] vector_addr,  // vector byte address
	output logic      [15:0] vector_word   // vector contents
);
	logic [7:0] mem [0:63];
	logic [5:0] sp;
	logic [7:0] last_rd;
	// a flag stays up until acknowledged, so a refused request is offered again
	always_ff @(posedge clock) begin
		if (reset) begin
			irq_request <= 8'h00;
			top_request <= 1'b0;
		end else begin
			irq_request <= (irq_request & ~irq_ack) | raise;
			top_request <= (top_request & ~top_ack) | raise_top;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			sp <= 6'h00;
			last_rd <= 8'h00;
		end else if (stack_push) begin
			mem[sp] <= stack_wdata;
			sp <= sp + 6'h01;
		end else if (stack_pop) begin
			last_rd <= mem[sp - 6'h01];
			sp <= sp - 6'h01;
		end
	end
	// idle lines show the inverse of the last value so a stale sample cannot pass
	assign stack_rdata = stack_pop ? mem[sp - 6'h01] : ~last_rd;
	assign vector_word = vector_fetch ? {vector_addr[7:0], 8'h5A} : ~{vector_addr[7:0], 8'h5A};
endmodule : core_model

/* sim/tb_top.sv */
// self-checking bench for the interrupt priority arbiter
`timescale 1ns/1ps
module tb_top;
	import irq_arb_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
	logic        instr_boundary = 1'b0, enable_interrupts_instr = 1'b0, iret_instr = 1'b0;
	logic [15:0] pc_current = 16'h0000, vector_word, pc_value;
	logic [7:0]  flag_register = 8'h00, raise = 8'h00;
	logic        raise_top = 1'b0;
	logic [7:0]  irq_request, irq_ack, stack_wdata, stack_rdata, flags_value, active_segment;
	logic        wb_ack_o, top_request, top_ack, stack_push, stack_pop, vector_fetch;
	logic        pc_load, flags_load, global_irq_enable;
	logic [21:0] vector_addr;
	logic [7:0]  pushq [$];
	int          failures = 0;
	int          compares = 0;

	always #4 clock = ~clock;
	always @(posedge clock) if (stack_push === 1'b1) pushq.push_back(stack_wdata);

	interrupt_priority_arbiter i_interrupt_priority_arbiter (
		.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .irq_request, .irq_ack, .top_request, .top_ack, .instr_boundary,
		.enable_interrupts_instr, .iret_instr, .pc_current, .flag_register, .stack_push, .stack_wdata,
		.stack_pop, .stack_rdata, .vector_fetch, .vector_addr, .vector_word, .pc_load, .pc_value,
		.flags_load, .flags_value, .active_segment, .global_irq_enable
	);
	core_model i_core_model (
		.clock, .reset, .raise, .raise_top, .irq_ack, .top_ack, .irq_request, .top_request,
		.stack_push, .stack_wdata, .stack_pop, .stack_rdata, .vector_fetch, .vector_addr, .vector_word
	);

	task automatic tally_and_finish;
		if (failures == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	task automatic give_up;
		failures++;
		tally_and_finish();
	endtask : give_up

	task automatic check(input logic [21:0] seen, input logic [21:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// single classic cycle; the request is held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] wd, output logic [15:0] rd);
		int n;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {2'b00, idx, 2'b00};
		wb_sel_i <= 4'hF;
		wb_dat_i <= {16'h0000, wd};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) give_up();
		rd = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		logic [15:0] dummy;
		wb(1'b1, idx, d, dummy);
	endtask : wr

	task automatic rchk(input logic [7:0] idx, input logic [15:0] exp);
		logic [15:0] d;
		wb(1'b0, idx, 16'h0000, d);
		check(d, exp);
	endtask : rchk

	task automatic rq(input logic [7:0] r, input logic t);
		@(posedge clock);
		raise <= r;
		raise_top <= t;
		@(posedge clock);
		raise <= 8'h00;
		raise_top <= 1'b0;
	endtask : rq

	task automatic pulse_enable;
		@(posedge clock);
		enable_interrupts_instr <= 1'b1;
		@(posedge clock);
		enable_interrupts_instr <= 1'b0;
	endtask : pulse_enable

	task automatic wait_load(input logic [21:0] va, input logic chk);
		int n;
		n = 0;
		while (pc_load !== 1'b1 && n < 12) begin
			@(negedge clock);
			n++;
			if (chk && vector_fetch === 1'b1) begin
				check(vector_addr, va);
				check(global_irq_enable, 1'b0);
			end
		end
		if (n >= 12) give_up();
	endtask : wait_load

	task automatic entry(input logic [7:0] ea, input logic et, input logic [21:0] va, input logic [15:0] pv,
			input logic sv, input logic [7:0] cs);
		@(posedge clock);
		instr_boundary <= 1'b1;
		pc_current <= pv;
		flag_register <= ~pv[7:0];
		@(negedge clock);
		check(irq_ack, ea);
		check(top_ack, et);
		pushq.delete();
		@(posedge clock);
		instr_boundary <= 1'b0;
		if (ea !== 8'h00 || et) begin
			wait_load(va, 1'b1);
			check(pc_value, {va[7:0], 8'h5A});
			check(22'(pushq.size()), sv ? 22'd4 : 22'd3);
			check(pushq[0], pv[7:0]);
			check(pushq[1], pv[15:8]);
			if (sv) check(pushq[2], cs);
			check(pushq[sv ? 3 : 2], 8'(~pv[7:0]));
		end
	endtask : entry

	task automatic ret(input logic [15:0] pv, input logic [7:0] seg);
		@(posedge clock);
		iret_instr <= 1'b1;
		@(posedge clock);
		iret_instr <= 1'b0;
		wait_load(22'h0, 1'b0);
		check(pc_value, pv);
		check(flags_value, 8'(~pv[7:0]));
		@(negedge clock);
		check(global_irq_enable, 1'b1);
		check(active_segment, seg);
	endtask : ret

	initial begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rchk(IDX_CENTRAL, 16'h0007);
		rchk(IDX_PRIO_LO, 16'h7777);
		rchk(IDX_PRIO_HI, 16'h7777);
		wr(8'h10, 16'h00FF);
		rchk(8'h10, 16'h0000);
		wr(IDX_INT_SEG, 16'h0011);
		wr(IDX_VECTOR, 16'h00A0);
		wr(IDX_CENTRAL, 16'h0015);
		rchk(IDX_CENTRAL, 16'h0015);
		wr(IDX_CENTRAL, 16'h0017);
		rq(8'hFF, 1'b0);
		entry(8'h00, 1'b0, 22'h0, 16'h0000, 1'b0, 8'h00);
		wr(IDX_CENTRAL, 16'h0007);
		wr(IDX_PRIO_LO, 16'h3333);
		wr(IDX_PRIO_HI, 16'h3333);
		entry(8'h00, 1'b0, 22'h0, 16'h0000, 1'b0, 8'h00);
		pulse_enable();
		rchk(IDX_CENTRAL, 16'h0017);
		// equal levels nest eight deep, each ack picked by chain position
		for (int i = 0; i < 8; i++) begin
			entry(8'h01 << i, 1'b0, {6'h11, 8'h00, 8'hA0 | 8'(i << 1)}, {8'h40, 8'(i)}, 1'b0, 8'h00);
			check(active_segment, 8'h11);
			pulse_enable();
		end
		rchk(IDX_CENTRAL, 16'h0017);
		for (int i = 7; i >= 0; i--) ret({8'h40, 8'(i)}, (i == 0) ? 8'h00 : 8'h11);
		rchk(IDX_CENTRAL, 16'h0017);
		wr(IDX_CENTRAL, 16'h0013);
		rq(8'h01, 1'b0);
		entry(8'h00, 1'b0, 22'h0, 16'h0000, 1'b0, 8'h00);
		wr(IDX_PRIO_LO, 16'h3332);
		wr(IDX_EMR_TWO, 16'h0040);
		wr(IDX_CODE_SEG, 16'h002A);
		entry(8'h01, 1'b0, {6'h11, 8'h00, 8'hA0}, 16'h1234, 1'b1, 8'h2A);
		// the code segment is reloaded on the vector step and shows one cycle later
		@(negedge clock);
		check(active_segment, 8'h11);
		ret(16'h1234, 8'h2A);
		wr(IDX_TOP_CFG, 16'h0001);
		wr(IDX_CENTRAL, 16'h0017);
		rq(8'h01, 1'b1);
		entry(8'h00, 1'b1, {6'h11, 8'h00, 8'h04}, 16'h5678, 1'b1, 8'h2A);
		pulse_enable();
		rchk(IDX_CENTRAL, 16'h0057);
		entry(8'h00, 1'b0, 22'h0, 16'h0000, 1'b1, 8'h00);
		ret(16'h5678, 8'h2A);
		entry(8'h01, 1'b0, {6'h11, 8'h00, 8'hA0}, 16'h9ABC, 1'b1, 8'h2A);
		ret(16'h9ABC, 8'h2A);
		// nested mode: the level follows the routine and comes back on return
		wr(IDX_CENTRAL, 16'h001F);
		rq(8'h01, 1'b0);
		entry(8'h01, 1'b0, {6'h11, 8'h00, 8'hA0}, 16'h2468, 1'b1, 8'h2A);
		rchk(IDX_CENTRAL, 16'h000A);
		ret(16'h2468, 8'h2A);
		rchk(IDX_CENTRAL, 16'h001F);
		tally_and_finish();
	end
endmodule : tb_top
